// ===== hdl/hac_pkg.sv
/*
 * hac_pkg: constants, field positions and types shared by the
 * dual link controller register front end.
 * assumes one clock and one reset shared by every user of the package.
 */
package hac_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NCTL       = 2;
   localparam int ADDR_W     = 12;
   localparam int FIFO_DEPTH = 4;
   localparam int PTR_W      = 2;
   localparam logic [PTR_W:0] FIFO_FULL = 3'h4;
   localparam logic [PTR_W:0] FIFO_ALMOST = 3'h3;

   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index, page in bit 10)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_ADR1  = 8'h10;
   localparam logic [7:0] IDX_ADR2  = 8'h11;
   localparam logic [7:0] IDX_FIFO  = 8'h12;
   localparam logic [7:0] IDX_CTL1  = 8'h13;
   localparam logic [7:0] IDX_STAT  = 8'h14;
   localparam logic [7:0] IDX_CTL2  = 8'h15;
   localparam logic [7:0] IDX_MASK  = 8'h16;
   localparam logic [7:0] IDX_FLAGS = 8'h17;
   localparam logic [7:0] IDX_CRCH  = 8'h18;
   localparam logic [7:0] IDX_CRCL  = 8'h19;
   localparam logic [7:0] IDX_TXLEN = 8'h1a;
   localparam logic [7:0] IDX_TCTL  = 8'h1b;
   localparam logic [7:0] IDX_TSTAT = 8'h1c;
   localparam logic [7:0] IDX_CTL3  = 8'h1d;
   localparam logic [7:0] IDX_CTL4  = 8'h1e;
   localparam logic [7:0] IDX_CLR   = 8'h1f;
   localparam int         PAGE_BIT  = 10;

   // ----------------------------------------------------------------
   // field positions and reset value
   // ----------------------------------------------------------------
   localparam int MASK_EN     = 0;
   localparam int C1_ADREC    = 7;
   localparam int C1_RXEN     = 6;
   localparam int C1_EOP      = 4;
   localparam int C1_FA       = 3;
   localparam int C2_SEVEN    = 4;
   localparam int C2_RXFRST   = 1;
   localparam int C2_TXFRST   = 0;
   localparam int EV_TEOP     = 5;
   localparam int EV_EOPR     = 4;
   localparam int EV_RXFF     = 1;
   localparam int EV_RXOVFL   = 0;
   localparam logic [7:0] REG_RST  = 8'h00;
   localparam logic [6:0] ALL_CALL = 7'h7f;

   // ----------------------------------------------------------------
   // receive byte status codes
   // ----------------------------------------------------------------
   localparam logic [1:0] RQ_PKT   = 2'h0;
   localparam logic [1:0] RQ_FIRST = 2'h1;
   localparam logic [1:0] RQ_GOOD  = 2'h2;
   localparam logic [1:0] RQ_BAD   = 2'h3;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] tag;     // tx: {end_packet_tag, abort_tag}; rx: status
      logic [7:0] data;
   } hac_entry_t;

   typedef struct packed {
      logic       valid;
      logic       first;
      logic       last;
      logic       bad;
      logic [7:0] data;
   } hac_rxbyte_t;

   typedef struct packed {
      logic [7:0] ctl_one;
      logic [7:0] ctl_two;
      logic [7:0] ctl_three;
      logic [7:0] ctl_four;
      logic [7:0] test_ctl;
      logic [7:0] tx_len;
   } hac_cfg_t;

   typedef enum logic [1:0] {
      AR_IDLE  = 2'b00,
      AR_WAIT2 = 2'b01,
      AR_PASS  = 2'b10,
      AR_DROP  = 2'b11
   } hac_ar_t;

endpackage

// ===== hdl/hac_front.sv
/*
 * hac_front: APB register front end of two identical link controllers,
 * with receive address filtering, tagged transmit queue and receive queue.
 * assumes the bit engine shares pclk, presents one received byte per
 * strobe with at least one idle cycle between strobes, and takes queued
 * transmit entries by valid/ready.
 */
`timescale 1ns/1ps

// Summary of operation
// [R1] Two identical controller register sets sit on two pages with the same layout.
// [R2] The first address byte is compared against the six-bit mask in bits 7 to 2.
// [R3] Bit 1 of the first mask joins the compare only when the seven-bit control is one.
// [R4] The first-byte mask is used only while its enable bit 0 is high.
// [R5] With filtering on, a packet failing the compare puts no byte in the receive queue.
// [R6] The one-byte all-call address of seven ones is honoured only with the first enable high.
// [R7] The second address byte is compared against the seven-bit mask in bits 7 to 1.
// [R8] An all-call address overrides both masks and the packet is accepted.
// [R9] The second-byte mask is used only while its enable bit 0 is one.
// [R10] Two-byte all-call is honoured only while the second enable bit is one.
// [R11] A write to the queue address stores the byte with end and abort tags as 10 bits.
// [R12] A read of the queue address returns the next received byte, its status in status.
// [R13] Queue status shows the pointers one cycle after the access, not at once.
// [R14] Filtering happens only while the recognition enable in control one is set.
// [R15] An end-tagged entry marks frame end for the sender and the tags self-clear on write.
// [R16] Byte status codes are 00 packet, 01 first, 10 good last and 11 bad last.
// [R17] With filtering on but neither mask enabled, every address matches.
module hac_front
   import hac_pkg::*;
(
   // apb slave
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [ADDR_W-1:0]          paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   // interrupt
   output logic                            irq,
   // receive side of the bit engines
   input  wire hac_rxbyte_t [NCTL-1:0]     rx_in,
   input  wire logic [NCTL-1:0][15:0]      rx_crc,
   input  wire logic [NCTL-1:0]            line_idle,
   input  wire logic [NCTL-1:0][7:0]       engine_events,
   input  wire logic [NCTL-1:0][7:0]       test_flags,
   // transmit side of the bit engines
   output wire hac_entry_t [NCTL-1:0]      tx_entry,
   output wire logic [NCTL-1:0]            tx_valid,
   input  wire logic [NCTL-1:0]            tx_ready,
   // configuration to the bit engines
   output wire hac_cfg_t [NCTL-1:0]        cfg
);

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic [7:0]            idx;
   logic                  pg;
   logic                  mapped;
   logic                  wr_go;
   logic                  rd_go;
   wire  [NCTL-1:0][7:0]  rd_val;
   wire  [NCTL-1:0]       irq_vec;
   logic [31:0]           next_prdata;
   logic                  next_pready;
   logic                  next_pslverr;
   logic                  next_irq;

   // page, index and strobes of the current access
   always_comb begin
      idx    = paddr[9:2];
      pg     = paddr[PAGE_BIT];                      // see [R1]
      mapped = (paddr[ADDR_W-1] == 1'b0) && (paddr[1:0] == 2'h0)
               && (idx >= IDX_ADR1) && (idx <= IDX_CLR);
      wr_go  = psel && penable && pready && pwrite && mapped;
      rd_go  = psel && penable && pready && !pwrite && mapped;
   end

   // zero-wait answer, read data captured in the setup cycle
   always_comb begin
      next_pready  = psel && !penable;
      next_pslverr = psel && !penable && !mapped;
      next_prdata  = prdata;
      if (psel && !penable && !pwrite) begin
         next_prdata = mapped ? {24'h000000, rd_val[pg]} : 32'h00000000;
      end
      next_irq = |irq_vec;
   end

   // bus answer and interrupt registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         irq     <= next_irq;
      end
   end

   // ----------------------------------------------------------------
   // one controller per page
   // ----------------------------------------------------------------
   for (genvar c = 0; c < NCTL; c++) begin : g_ctl
      logic [7:0]                   adr1, next_adr1;
      logic [7:0]                   adr2, next_adr2;
      logic [7:0]                   ctl1, next_ctl1;
      logic [7:0]                   ctl2, next_ctl2;
      logic [7:0]                   ctl3, next_ctl3;
      logic [7:0]                   ctl4, next_ctl4;
      logic [7:0]                   evmask, next_evmask;
      logic [7:0]                   flags, next_flags;
      logic [7:0]                   txlen, next_txlen;
      logic [7:0]                   tctl, next_tctl;
      hac_entry_t [FIFO_DEPTH-1:0]  rxm, next_rxm;
      hac_entry_t [FIFO_DEPTH-1:0]  txm, next_txm;
      logic [PTR_W:0]               rxw, next_rxw;
      logic [PTR_W:0]               rxr, next_rxr;
      logic [PTR_W:0]               txw, next_txw;
      logic [PTR_W:0]               txr, next_txr;
      hac_ar_t                      ar, next_ar;
      hac_entry_t                   hold, next_hold;
      logic                         hold_v, next_hold_v;
      logic                         a1ok, next_a1ok;
      logic                         a1all, next_a1all;
      logic [5:0]                   stat, next_stat;
      hac_entry_t                   txo, next_txo;
      logic                         txov, next_txov;
      logic                         wsel;
      logic                         rxv;
      logic                         m1;
      logic                         m2;
      logic                         allc;
      logic                         filt;
      logic                         push;
      logic                         rx_full;
      logic                         rx_empty;
      logic                         tx_full;
      logic                         tx_empty;
      logic [7:0]                   ev_set;
      logic [7:0]                   clr;
      logic [7:0]                   rdv;
      hac_entry_t                   inb;

      // register writes, address filter, queues and event flags
      always_comb begin
         next_adr1   = adr1;
         next_adr2   = adr2;
         next_ctl1   = ctl1;
         next_ctl2   = ctl2;
         next_ctl3   = ctl3;
         next_ctl4   = ctl4;
         next_evmask = evmask;
         next_txlen  = txlen;
         next_tctl   = tctl;
         next_rxm    = rxm;
         next_txm    = txm;
         next_rxw    = rxw;
         next_rxr    = rxr;
         next_txw    = txw;
         next_txr    = txr;
         next_ar     = ar;
         next_hold   = hold;
         next_hold_v = hold_v;
         next_a1ok   = a1ok;
         next_a1all  = a1all;
         next_txo    = txo;
         next_txov   = txov;
         ev_set      = engine_events[c];
         clr         = 8'h00;
         push        = 1'b0;
         wsel        = wr_go && (pg == 1'(c));
         rx_full     = (rxw - rxr) == FIFO_FULL;
         rx_empty    = rxw == rxr;
         tx_full     = (txw - txr) == FIFO_FULL;
         tx_empty    = txw == txr;
         rxv         = rx_in[c].valid;

         // software writes to the page
         if (wsel) begin
            unique case (idx)
               IDX_ADR1:  next_adr1   = pwdata[7:0];
               IDX_ADR2:  next_adr2   = pwdata[7:0];
               IDX_CTL1:  next_ctl1   = pwdata[7:0];
               IDX_CTL2:  next_ctl2   = pwdata[7:0];
               IDX_CTL3:  next_ctl3   = pwdata[7:0];
               IDX_CTL4:  next_ctl4   = pwdata[7:0];
               IDX_MASK:  next_evmask = pwdata[7:0];
               IDX_TXLEN: next_txlen  = pwdata[7:0];
               IDX_TCTL:  next_tctl   = pwdata[7:0];
               IDX_CLR:   clr         = pwdata[7:0];
               IDX_FIFO: begin
                  if (!tx_full) begin
                     next_txm[txw[PTR_W-1:0]] =
                        '{tag: {ctl1[C1_EOP], ctl1[C1_FA]}, data: pwdata[7:0]}; // see [R11]
                     next_txw = txw + 3'h1;
                  end
                  next_ctl1[C1_EOP] = 1'b0;                 // see [R15]
                  next_ctl1[C1_FA]  = 1'b0;
               end
               default: ;
            endcase
         end

         // status code of the incoming byte
         if (rx_in[c].last) begin
            inb.tag = rx_in[c].bad ? RQ_BAD : RQ_GOOD;      // see [R16]
         end else begin
            inb.tag = rx_in[c].first ? RQ_FIRST : RQ_PKT;
         end
         inb.data = rx_in[c].data;

         // address compares
         m1   = !adr1[MASK_EN]                                    // see [R4]
                || ((rx_in[c].data[7:2] == adr1[7:2])             // see [R2]
                    && (!ctl2[C2_SEVEN] || (rx_in[c].data[1] == adr1[1]))); // see [R3]
         m2   = rx_in[c].data[7:1] == adr2[7:1];                  // see [R7]
         allc = rx_in[c].data[7:1] == ALL_CALL;
         filt = ctl1[C1_ADREC]                                    // see [R14]
                && (adr1[MASK_EN] || adr2[MASK_EN]);              // see [R17]

         // receive filter: one byte held back until a verdict
         unique case (ar)
            AR_IDLE: begin
               if (rxv && rx_in[c].first && ctl1[C1_RXEN]) begin
                  next_hold   = inb;
                  next_hold_v = 1'b1;
                  if (!filt) begin
                     next_ar = AR_PASS;
                  end else if (adr2[MASK_EN] && !rx_in[c].last) begin // see [R9]
                     next_ar    = AR_WAIT2;
                     next_a1ok  = m1;
                     next_a1all = allc;
                  end else if (adr2[MASK_EN]) begin
                     next_hold_v = 1'b0;                  // too short to match
                  end else if (m1 || (adr1[MASK_EN] && allc)) begin // see [R6]
                     next_ar = AR_PASS;
                  end else begin
                     next_hold_v = 1'b0;                  // see [R5]
                     next_ar     = rx_in[c].last ? AR_IDLE : AR_DROP;
                  end
               end
            end
            AR_WAIT2: begin
               if (rxv) begin
                  if (a1all || (a1ok && m2)) begin        // see [R8], [R10]
                     push      = 1'b1;
                     next_hold = inb;
                     next_ar   = AR_PASS;
                  end else begin
                     next_hold_v = 1'b0;                  // see [R5]
                     next_ar     = rx_in[c].last ? AR_IDLE : AR_DROP;
                  end
               end
            end
            AR_PASS: begin
               if (hold_v && hold.tag[1]) begin
                  push        = 1'b1;                     // flush the last byte
                  next_hold_v = 1'b0;
                  next_ar     = AR_IDLE;
               end else if (rxv) begin
                  push      = 1'b1;
                  next_hold = inb;
               end
            end
            AR_DROP: begin
               if (rxv && rx_in[c].last) begin
                  next_ar = AR_IDLE;
               end
            end
         endcase

         // receive queue write and software pop
         if (push) begin
            if (!rx_full) begin
               next_rxm[rxw[PTR_W-1:0]] = hold;
               next_rxw = rxw + 3'h1;
               ev_set[EV_EOPR] = ev_set[EV_EOPR] | hold.tag[1];
               ev_set[EV_RXFF] = ev_set[EV_RXFF] | ((rxw - rxr) == FIFO_ALMOST);
            end else begin
               ev_set[EV_RXOVFL] = 1'b1;
            end
         end
         if (rd_go && (pg == 1'(c)) && (idx == IDX_FIFO) && !rx_empty) begin
            next_rxr = rxr + 3'h1;                        // see [R12]
         end

         // transmit queue drain into the output stage
         if (txov && tx_ready[c] && txo.tag[1]) begin
            ev_set[EV_TEOP] = 1'b1;                       // see [R15]
         end
         if (!txov || tx_ready[c]) begin
            next_txov = !tx_empty;
            if (!tx_empty) begin
               next_txo = txm[txr[PTR_W-1:0]];
               next_txr = txr + 3'h1;
            end
         end

         // queue flushes from control two
         if (ctl2[C2_RXFRST]) begin
            next_rxr = next_rxw;
         end
         if (ctl2[C2_TXFRST]) begin
            next_txr  = next_txw;
            next_txov = 1'b0;
         end

         // sticky flags, a new event wins over a clear
         next_flags = (flags & ~clr) | ev_set;

         // status snapshot lags the pointers by one cycle
         next_stat = {rxm[rxr[PTR_W-1:0]].tag, tx_full, tx_empty, rx_full, rx_empty}; // see [R13]
      end

      // register read mux of this page
      always_comb begin
         unique case (idx)
            IDX_ADR1:  rdv = adr1;
            IDX_ADR2:  rdv = adr2;
            IDX_FIFO:  rdv = rx_empty ? 8'h00 : rxm[rxr[PTR_W-1:0]].data; // see [R12]
            IDX_CTL1:  rdv = ctl1;
            IDX_STAT:  rdv = {|(flags & evmask), line_idle[c], stat};
            IDX_CTL2:  rdv = ctl2;
            IDX_MASK:  rdv = evmask;
            IDX_FLAGS: rdv = flags;
            IDX_CRCH:  rdv = rx_crc[c][15:8];
            IDX_CRCL:  rdv = rx_crc[c][7:0];
            IDX_TXLEN: rdv = txlen;
            IDX_TCTL:  rdv = tctl;
            IDX_TSTAT: rdv = test_flags[c];
            IDX_CTL3:  rdv = ctl3;
            IDX_CTL4:  rdv = ctl4;
            default:   rdv = 8'h00;
         endcase
      end

      // controller state registers
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            adr1   <= REG_RST;
            adr2   <= REG_RST;
            ctl1   <= REG_RST;
            ctl2   <= REG_RST;
            ctl3   <= REG_RST;
            ctl4   <= REG_RST;
            evmask <= REG_RST;
            flags  <= REG_RST;
            txlen  <= REG_RST;
            tctl   <= REG_RST;
            rxm    <= '0;
            txm    <= '0;
            rxw    <= '0;
            rxr    <= '0;
            txw    <= '0;
            txr    <= '0;
            ar     <= AR_IDLE;
            hold   <= '0;
            hold_v <= 1'b0;
            a1ok   <= 1'b0;
            a1all  <= 1'b0;
            stat   <= 6'h05;
            txo    <= '0;
            txov   <= 1'b0;
         end else begin
            adr1   <= next_adr1;
            adr2   <= next_adr2;
            ctl1   <= next_ctl1;
            ctl2   <= next_ctl2;
            ctl3   <= next_ctl3;
            ctl4   <= next_ctl4;
            evmask <= next_evmask;
            flags  <= next_flags;
            txlen  <= next_txlen;
            tctl   <= next_tctl;
            rxm    <= next_rxm;
            txm    <= next_txm;
            rxw    <= next_rxw;
            rxr    <= next_rxr;
            txw    <= next_txw;
            txr    <= next_txr;
            ar     <= next_ar;
            hold   <= next_hold;
            hold_v <= next_hold_v;
            a1ok   <= next_a1ok;
            a1all  <= next_a1all;
            stat   <= next_stat;
            txo    <= next_txo;
            txov   <= next_txov;
         end
      end

      // page outputs, all but the read mux value taken from registers
      assign rd_val[c]   = rdv;
      assign irq_vec[c]  = |(flags & evmask);
      assign tx_entry[c] = txo;
      assign tx_valid[c] = txov;
      assign cfg[c]      = {ctl1, ctl2, ctl3, ctl4, tctl, txlen};
   end

endmodule

// ===== tb/hac_front_asserts.sv
/* hac_front_asserts: port checker for hac_front, bound to the top.
   assumes pclk and presetn are the only clock and reset. */
`timescale 1ns/1ps
module hac_front_asserts
   import hac_pkg::*;
(
   // apb, transmit side and configuration
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [ADDR_W-1:0]      paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire hac_entry_t [NCTL-1:0]  tx_entry,
   input wire logic [NCTL-1:0]        tx_valid,
   input wire logic [NCTL-1:0]        tx_ready,
   input wire hac_cfg_t [NCTL-1:0]    cfg
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------------
   // bus phases
   // ----------------------------------------------------------------
   sequence s_setup; psel && !penable; endsequence
   sequence s_done; psel && penable && pready; endsequence
   property p_ready; s_setup |=> pready; endproperty
   property p_one; pready |=> !pready; endproperty
   property p_err; s_setup ##0 paddr[11] |=> pslverr; endproperty
   property p_hi; s_done ##0 !pwrite |-> prdata[31:8] == 24'h0; endproperty
   property p_ctl;
      s_done ##0 (pwrite && paddr == 12'h04c) |=> cfg[0].ctl_one == $past(pwdata[7:0]);
   endproperty
   property p_tag;
      s_done ##0 (pwrite && paddr == 12'h048) |=> cfg[0].ctl_one[4:3] == 2'h0;
   endproperty
   property p_hold;
      tx_valid[0] && !tx_ready[0] |=> tx_valid[0] && $stable(tx_entry[0]);
   endproperty
   property p_uerr; s_done ##0 (pslverr && !pwrite) |-> prdata == 32'h0; endproperty
   a_ready: assert property (p_ready) else $error("no answer after setup");
   a_one: assert property (p_one) else $error("ready longer than one cycle");
   a_err: assert property (p_err) else $error("unmapped not refused");
   a_hi: assert property (p_hi) else $error("upper read bits set");
   a_ctl: assert property (p_ctl) else $error("control one not written");
   a_tag: assert property (p_tag) else $error("tags not cleared");
   a_hold: assert property (p_hold) else $error("entry dropped early");
   a_uerr: assert property (p_uerr) else $error("unmapped read not zero");
endmodule
bind hac_front hac_front_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tx_entry(tx_entry), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .cfg(cfg));

// ===== tb/hac_front_tb.sv
/* hac_front_tb: self-checking bench for hac_front.
   assumes the checker is bound separately; page 0 carries traffic. */
`timescale 1ns/1ps
module hac_front_tb;
   import hac_pkg::*;
   logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [ADDR_W-1:0]      paddr;
   logic [31:0]            pwdata, prdata, rd;
   hac_rxbyte_t [NCTL-1:0] rx_in;
   hac_entry_t [NCTL-1:0]  tx_entry;
   logic [NCTL-1:0]        tx_valid, tx_ready;
   hac_cfg_t [NCTL-1:0]    cfg;
   int                     n_errors, n_compared, cyc, s;
   logic [7:0]             m1, m2, c2, b1, b2;
   hac_front dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .rx_in(rx_in), .rx_crc('0), .line_idle('0),
      .engine_events('0), .test_flags('0), .tx_entry(tx_entry), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .cfg(cfg));
   // clock and hang guard
   initial begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic final_report;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [11:0] ra(input logic pg, input logic [7:0] ix);
      return {1'b0, pg, ix, 2'b00};
   endfunction
   // ----------------------------------------------------------------
   // bus and receive drivers
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // wait for the answer; only the cycle watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rxb(input logic f, input logic l, input logic [7:0] d);
      @(posedge pclk);
      rx_in[0] <= '{1'b1, f, l, 1'b0, d};
      @(posedge pclk);
      rx_in[0] <= '0;
   endtask
   // expected verdict of the address filter
   function automatic logic acc(input logic r);
      if (!r || (!m1[0] && !m2[0])) return 1;
      if (b1[7:1] == ALL_CALL) return 1;
      return (!m1[0] || (b1[7:2] == m1[7:2] && (!c2[4] || b1[1] == m1[1])))
         && (!m2[0] || b2[7:1] == m2[7:1]);
   endfunction
   task automatic pkt(input logic r);
      logic [7:0] dq[3];
      logic [1:0] sq[3];
      dq = '{b1, b2, 8'h5a};
      sq = '{RQ_FIRST, RQ_PKT, RQ_GOOD};
      apb(1, ra(0, IDX_ADR1), m1);
      apb(1, ra(0, IDX_ADR2), m2);
      apb(1, ra(0, IDX_CTL2), c2 & 8'h10);
      apb(1, ra(0, IDX_CTL1), {r, 7'h40});
      rxb(1, 0, b1);
      rxb(0, 0, b2);
      rxb(0, 1, 8'h5a);
      repeat (4) @(posedge pclk);
      apb(0, ra(0, IDX_STAT), 0);
      chk(rd[0], !acc(r));
      for (int i = 0; i < 3 && acc(r); i++) begin
         apb(0, ra(0, IDX_STAT), 0);
         chk(rd[5:4], sq[i]);
         apb(0, ra(0, IDX_FIFO), 0);
         chk(rd, dq[i]);
      end
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, rx_in, tx_ready, cyc} = '0;
      s = $urandom(37261);
      repeat (20) @(posedge pclk);
      presetn <= 1;
      for (int ix = 'h10; ix < 'h1f; ix++) if (ix != 'h1c) begin
         apb(0, ra(0, ix[7:0]), 0);
         chk(rd, (ix == IDX_STAT) ? 32'h5 : 32'h0);
      end
      // unmapped index and bit 11 set are both refused
      apb(0, 12'h000, 0);
      chk(er, 1);
      chk(rd, 0);
      apb(0, 12'h84c, 0);
      chk(er, 1);
      m1 = 8'($urandom);
      m2 = 8'($urandom);
      apb(1, ra(0, IDX_ADR1), m1);
      apb(1, ra(1, IDX_ADR1), m2);
      apb(0, ra(0, IDX_ADR1), 0);
      chk(rd, m1);
      apb(0, ra(1, IDX_ADR1), 0);
      chk(rd, m2);
      {m1, m2, c2, b1, b2} = {8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
      pkt(0);
      {m1, b1} = {8'h00, 8'h33};
      pkt(1);
      {m1, b1} = {8'h81, 8'hfe};
      pkt(1);
      {m1, c2, b1} = {8'h83, 8'h10, 8'h80};
      pkt(1);
      c2 = 8'h00;
      pkt(1);
      {m1, m2, b1, b2} = {8'h00, 8'h41, 8'h10, 8'h40};
      pkt(1);
      {b1, b2} = {8'hfe, 8'h22};
      pkt(1);
      for (int i = 0; i < 12; i++) begin
         {m1, m2, c2} = {8'($urandom), 8'($urandom), 8'($urandom)};
         b1 = $urandom_range(1) ? m1 : 8'($urandom);
         b2 = $urandom_range(1) ? m2 : 8'($urandom);
         pkt(1);
      end
      // end-of-packet event raised, masked, cleared
      apb(0, ra(0, IDX_FLAGS), 0);
      chk({rd[4], irq}, 2'b10);
      apb(1, ra(0, IDX_MASK), 8'h10);
      repeat (2) @(posedge pclk);
      chk(irq, 1);
      apb(1, ra(0, IDX_CLR), 8'h10);
      repeat (2) @(posedge pclk);
      chk(irq, 0);
      // tagged transmit entry held until taken
      apb(1, ra(0, IDX_CTL1), 8'h18);
      apb(1, ra(0, IDX_FIFO), 8'ha5);
      repeat (2) @(posedge pclk);
      chk({tx_valid[0], tx_entry[0]}, 11'h7a5);
      apb(0, ra(0, IDX_CTL1), 0);
      chk(rd, 0);
      tx_ready <= 2'b11;
      repeat (4) @(posedge pclk);
      chk(tx_valid, 0);
      final_report();
   end
endmodule
